// [dv/port_pin_model.sv]
// Purpose: Counter datapath levels and port pads around the control block
// Assumes: Generator levels come straight from the bench
// Notes: A pad not set as output sits at its pull-up level
`timescale 1ns/1ps
module port_pin_model (
  input wire logic [2:0] i_level_req,
  input wire logic [2:0] i_pin_override,
  input wire logic [2:0] i_wave_pin,
  input wire logic [2:0] i_pin_is_output,
  input wire logic [2:0] i_port_out,
  output logic [2:0] o_wave_gen,
  output logic [2:0] o_pad
);
  // Levels as the counter datapath would report them
  assign o_wave_gen = i_level_req;
  // An output pad shows the wave only when steered, else the port value
  always_comb
  begin
    for (int n = 0; n < 3; n++)
    begin
      if (!i_pin_is_output[n])
        o_pad[n] = 1'b1;
      else
        o_pad[n] = i_pin_override[n] ? i_wave_pin[n] : i_port_out[n];
    end
  end
endmodule // port_pin_model

// [dv/tb.sv]
// Purpose: Register-level bench for the timer control block
// Assumes: Strobe bus with read data in the cycle after the read
// Notes: Pins are judged at the control block outputs and at the pads of the partner model
`timescale 1ns/1ps
module tb;
  logic i_mclk, i_arst_n = 1'b0, i_clk_en = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic i_update_cond = 1'b0, i_hw_dir_valid = 1'b0, i_hw_dir = 1'b0;
  logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
  logic [2:0] wave_gen, pad, level_req = 3'h0, pin_is_output = 3'h3, port_out = 3'h0;
  logic [2:0] o_wave_shape_select, o_channel_pin_override, o_channel_wave_pin;
  logic [2:0] o_custom_logic_level;
  logic o_timer_run, o_dual_8bit_select, o_count_down, o_transfer_lock;
  logic o_buffer_transfer, o_force_restart, o_force_hard_reset;
  logic [2:0] modes [6] = '{3'h0, 3'h1, 3'h3, 3'h5, 3'h6, 3'h7};
  logic [2:0] cmd_pulse [4] = '{3'h0, 3'h4, 3'h2, 3'h1};
  int err_count = 0;
  int cmp_count = 0;

  timer_waveform_control_regs DUT (.i_mclk, .i_arst_n, .i_clk_en, .i_addr, .i_wdata,
    .i_wr, .i_rd, .i_update_cond, .i_hw_dir_valid, .i_hw_dir, .i_wave_gen(wave_gen),
    .o_rdata, .o_timer_run, .o_wave_shape_select, .o_dual_8bit_select, .o_count_down,
    .o_transfer_lock, .o_buffer_transfer, .o_force_restart, .o_force_hard_reset,
    .o_channel_pin_override, .o_channel_wave_pin, .o_custom_logic_level);
  port_pin_model pins (.i_level_req(level_req), .i_pin_override(o_channel_pin_override),
    .i_wave_pin(o_channel_wave_pin), .i_pin_is_output(pin_is_output),
    .i_port_out(port_out), .o_wave_gen(wave_gen), .o_pad(pad));

  // 10 MHz clock
  initial
  begin
    i_mclk = 1'b0;
    forever #50 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Bus cycles; each returns just after the edge that took the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(o_rdata, exp);
  endtask

  // One-cycle pulses from the counter datapath side
  task automatic pulse(input logic upd, input logic hw);
    @(posedge i_mclk);
    i_update_cond <= upd;
    i_hw_dir_valid <= hw;
    i_hw_dir <= hw;
    @(posedge i_mclk);
    i_update_cond <= 1'b0;
    i_hw_dir_valid <= 1'b0;
    #1;
  endtask

  // Lets the registered pin outputs catch up with the control state
  task automatic tick;
    @(posedge i_mclk);
    #1;
  endtask

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Hang guard, well beyond the 160 or so cycles of the tests
  initial
  begin
    repeat (3000) @(posedge i_mclk);
    err_count++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    for (int a = 0; a < 9; a++)
      rd(8'(a), 8'h00);
    $display("reset values done");
    foreach (modes[m])
    begin
      wr(8'h01, {5'h00, modes[m]});
      chk(o_wave_shape_select, modes[m]);
      rd(8'h01, {5'h00, modes[m]});
    end
    // Strobes while the clock enable is low must be dropped
    @(posedge i_mclk);
    i_clk_en <= 1'b0;
    wr(8'h01, 8'h03);
    @(posedge i_mclk);
    i_clk_en <= 1'b1;
    rd(8'h01, 8'h07);
    $display("mode select done");
    wr(8'h01, 8'h31);
    wr(8'h02, 8'h05);
    tick();
    chk(o_channel_wave_pin, 3'h5);
    chk(o_custom_logic_level, 3'h5);
    chk(o_channel_pin_override, 3'h3);
    chk(pad, 3'h5);
    // Reserved shapes drive no pin, a dual-ramp shape does
    wr(8'h01, 8'h32);
    tick();
    chk(o_channel_pin_override, 3'h0);
    wr(8'h01, 8'h35);
    tick();
    chk(o_channel_pin_override, 3'h3);
    wr(8'h01, 8'h34);
    tick();
    chk(o_channel_pin_override, 3'h0);
    wr(8'h01, 8'h35);
    wr(8'h01, 8'h30);
    tick();
    chk(o_channel_pin_override, 3'h0);
    chk(pad, 3'h4);
    wr(8'h01, 8'h31);
    @(posedge i_mclk);
    level_req <= 3'h6;
    wr(8'h00, 8'h01);
    chk(o_timer_run, 1'b1);
    wr(8'h02, 8'h00);
    repeat (2) @(posedge i_mclk);
    #1;
    chk(o_channel_wave_pin, 3'h6);
    chk(pad, 3'h6);
    wr(8'h00, 8'h00);
    chk(o_timer_run, 1'b0);
    $display("pin steering done");
    wr(8'h05, 8'h03);
    chk({o_transfer_lock, o_count_down}, 2'h3);
    wr(8'h04, 8'h01);
    chk({o_transfer_lock, o_count_down}, 2'h2);
    rd(8'h05, 8'h02);
    pulse(1'b0, 1'b1);
    chk(o_count_down, 1'b1);
    pulse(1'b1, 1'b0);
    chk(o_buffer_transfer, 1'b0);
    chk(o_transfer_lock, 1'b1);
    for (int c = 0; c < 4; c++)
    begin
      wr(8'h05, 8'(c << 2));
      chk({o_buffer_transfer, o_force_restart, o_force_hard_reset}, cmd_pulse[c]);
      rd(8'h05, (c < 3) ? 8'h03 : 8'h00);
    end
    wr(8'h00, 8'h01);
    wr(8'h04, 8'h0C);
    chk(o_force_hard_reset, 1'b0);
    wr(8'h00, 8'h00);
    $display("commands done");
    wr(8'h39, 8'h12);
    rd(8'h06, 8'h02);
    wr(8'h37, 8'h34);
    wr(8'h06, 8'h01);
    rd(8'h07, 8'h02);
    pulse(1'b1, 1'b0);
    chk(o_buffer_transfer, 1'b1);
    rd(8'h06, 8'h00);
    wr(8'h01, 8'h38);
    chk(o_transfer_lock, 1'b1);
    wr(8'h39, 8'h00);
    @(posedge i_mclk);
    #1;
    chk(o_transfer_lock, 1'b1);
    wr(8'h3B, 8'h00);
    @(posedge i_mclk);
    #1;
    chk(o_transfer_lock, 1'b0);
    pulse(1'b1, 1'b0);
    chk({o_buffer_transfer, o_transfer_lock}, 2'h3);
    rd(8'h06, 8'h00);
    $display("buffer lock done");
    wr(8'h03, 8'h01);
    chk(o_dual_8bit_select, 1'b1);
    rd(8'h03, 8'h01);
    $display("split done");
    // Reset in mid-run must return every control register to zero
    @(posedge i_mclk);
    i_arst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    #1;
    chk(o_dual_8bit_select, 1'b0);
    rd(8'h03, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h05, 8'h00);
    $display("mid-run reset done");
    close_out();
  end
endmodule // tb

// [logic/timer_ctrl_params.svh]
// Purpose: Offsets, field positions and reset values of the timer control registers
// Assumes: Byte-wide plain register port, register offsets used as byte addresses
// Notes: Functional notes follow below
// Functional notes
// - Timer runs only while enable bit set
// - Pin enable drives wave over port value
// - Auto-lock holds lock until enabled buffers valid
// - Update copies buffers, re-arms lock
// - Without auto-lock hardware never touches lock
// - Three-bit field selects count sequence
// - Normal mode drives no waveform
// - Level bits drive output while disabled
// - Pad override needs enable, custom logic bypasses
// - Split bit selects two 8-bit timers
// - Command decodes update, restart, hard reset
// - Command field always reads zero
// - Lock blocks buffered update on update condition
// - Forced update ignores lock
// - Direction bit up at 0, down at 1
// - Clear alias clears bits written one
// - Set alias sets bits written one
// - Buffer valid set on write, cleared on update
`ifndef TIMER_CTRL_PARAMS_SVH
`define TIMER_CTRL_PARAMS_SVH
`define TC_OFF_ENABLE 8'h00
`define TC_OFF_WAVE 8'h01
`define TC_OFF_LEVEL 8'h02
`define TC_OFF_SPLIT 8'h03
`define TC_OFF_CMD_CLR 8'h04
`define TC_OFF_CMD_SET 8'h05
`define TC_OFF_BV_CLR 8'h06
`define TC_OFF_BV_SET 8'h07
`define TC_OFF_PERIOD_BUF_HI 8'h37
`define TC_OFF_CMP0BUF_HI 8'h39
`define TC_OFF_CMP1BUF_HI 8'h3B
`define TC_OFF_CMP2BUF_HI 8'h3D
`define TC_BIT_ENABLE 0
`define TC_BIT_AUTOLOCK 3
`define TC_POS_PINEN 4
`define TC_POS_MODE 0
`define TC_BIT_SPLIT 0
`define TC_BIT_DIR 0
`define TC_BIT_LOCK 1
`define TC_POS_CMD 2
`define TC_POS_LEVEL 0
`define TC_POS_BV 0
`define TC_MODE_RSVD_LO 3'h2
`define TC_MODE_RSVD_HI 3'h4
`define TC_RESET_BYTE 8'h00
`define TC_RESET_3 3'h0
`define TC_RESET_4 4'h0
`endif

// [logic/timer_ctrl_pkg.sv]
// Purpose: Shared types of the timer control block
// Assumes: Used with timer_ctrl_params.svh
// Notes: Reserved wave shapes keep their codes but act as normal
package timer_ctrl_pkg;
  typedef enum logic [2:0] {
    NORMAL_COUNT = 3'h0,
    FREQUENCY_GENERATION = 3'h1,
    ONE_RAMP_PWM = 3'h3,
    TWO_RAMP_OVERFLOW_AT_PEAK = 3'h5,
    TWO_RAMP_OVERFLOW_AT_PEAK_AND_FLOOR = 3'h6,
    TWO_RAMP_OVERFLOW_AT_FLOOR = 3'h7
  } wave_shape_t;
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_UPDATE = 2'h1,
    CMD_RESTART = 2'h2,
    CMD_HARD_RESET = 2'h3
  } timer_cmd_t;
endpackage

// [logic/timer_waveform_control_regs.sv]
// Purpose: Control registers of a 16-bit three-channel timer, with pin steering
// Assumes: Counter datapath outside; it reports update conditions and wave levels
// Notes: All outputs registered; pin effects lag the control state one cycle, command pulses come with the write
`timescale 1ns/1ps
`include "timer_ctrl_params.svh"
module timer_waveform_control_regs (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_clk_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_update_cond,
  input wire logic i_hw_dir_valid,
  input wire logic i_hw_dir,
  input wire logic [2:0] i_wave_gen,
  output logic [7:0] o_rdata,
  output logic o_timer_run,
  output logic [2:0] o_wave_shape_select,
  output logic o_dual_8bit_select,
  output logic o_count_down,
  output logic o_transfer_lock,
  output logic o_buffer_transfer,
  output logic o_force_restart,
  output logic o_force_hard_reset,
  output logic [2:0] o_channel_pin_override,
  output logic [2:0] o_channel_wave_pin,
  output logic [2:0] o_custom_logic_level
);

  // Control state
  logic enable_q, enable_d;
  logic [2:0] pin_en_q, pin_en_d;
  logic autolock_q, autolock_d;
  logic [2:0] mode_q, mode_d;
  logic [2:0] level_q, level_d;
  logic split_q, split_d;
  logic lock_q, lock_d;
  logic dir_q, dir_d;
  logic [3:0] bv_q, bv_d;
  logic [7:0] rdata_q, rdata_d;
  logic xfer_q, xfer_d;
  logic restart_q, restart_d;
  logic hreset_q, hreset_d;
  logic [2:0] override_q, override_d;
  logic [2:0] pin_q, pin_d;
  logic [2:0] custom_lvl_q, custom_lvl_d;

  // Decoded strobes
  logic wr_en, wr_wave, wr_level, wr_split, wr_eclr, wr_eset, wr_fclr, wr_fset;
  logic [3:0] buf_written;
  logic [1:0] cmd_code;
  logic cmd_wr, force_update, hard_reset, update_xfer, all_valid;

  // Address decode of writes, all gated by the clock enable
  always_comb
  begin
    wr_en = i_clk_en && i_wr && (i_addr == `TC_OFF_ENABLE);
    wr_wave = i_clk_en && i_wr && (i_addr == `TC_OFF_WAVE);
    wr_level = i_clk_en && i_wr && (i_addr == `TC_OFF_LEVEL);
    wr_split = i_clk_en && i_wr && (i_addr == `TC_OFF_SPLIT);
    wr_eclr = i_clk_en && i_wr && (i_addr == `TC_OFF_CMD_CLR);
    wr_eset = i_clk_en && i_wr && (i_addr == `TC_OFF_CMD_SET);
    wr_fclr = i_clk_en && i_wr && (i_addr == `TC_OFF_BV_CLR);
    wr_fset = i_clk_en && i_wr && (i_addr == `TC_OFF_BV_SET);
    // A buffer counts as written once its high byte lands
    buf_written[0] = i_clk_en && i_wr && (i_addr == `TC_OFF_PERIOD_BUF_HI);
    buf_written[1] = i_clk_en && i_wr && (i_addr == `TC_OFF_CMP0BUF_HI);
    buf_written[2] = i_clk_en && i_wr && (i_addr == `TC_OFF_CMP1BUF_HI);
    buf_written[3] = i_clk_en && i_wr && (i_addr == `TC_OFF_CMP2BUF_HI);
  end

  // Command decode; either alias register carries the command field
  always_comb
  begin
    cmd_wr = wr_eclr || wr_eset;
    cmd_code = cmd_wr ? i_wdata[`TC_POS_CMD +: 2] : 2'h0;
    force_update = (cmd_code == timer_ctrl_pkg::CMD_UPDATE);
    // Hard reset only while stopped
    hard_reset = (cmd_code == timer_ctrl_pkg::CMD_HARD_RESET) && !enable_q;
    // Lock blocks the natural update, never the forced one
    update_xfer = (i_clk_en && i_update_cond && !lock_q) || force_update;
    // Channels not enabled are treated as already valid
    all_valid = &(bv_q[3:1] | ~pin_en_q);
  end

  // Next values of the software control registers
  always_comb
  begin
    enable_d = enable_q;
    pin_en_d = pin_en_q;
    autolock_d = autolock_q;
    mode_d = mode_q;
    level_d = level_q;
    split_d = split_q;
    lock_d = lock_q;
    dir_d = dir_q;
    bv_d = bv_q;
    if (wr_en)
      enable_d = i_wdata[`TC_BIT_ENABLE];
    if (wr_wave)
    begin
      pin_en_d = i_wdata[`TC_POS_PINEN +: 3];
      autolock_d = i_wdata[`TC_BIT_AUTOLOCK];
      mode_d = i_wdata[`TC_POS_MODE +: 3];
    end
    if (wr_level)
      level_d = i_wdata[`TC_POS_LEVEL +: 3];
    if (wr_split)
      split_d = i_wdata[`TC_BIT_SPLIT];
    // Hardware direction first, so a software write in the same cycle wins
    if (i_clk_en && i_hw_dir_valid)
      dir_d = i_hw_dir;
    // Alias writes touch only the bits written as one
    if (wr_eclr)
    begin
      if (i_wdata[`TC_BIT_DIR])
        dir_d = 1'b0;
      if (i_wdata[`TC_BIT_LOCK])
        lock_d = 1'b0;
    end
    if (wr_eset)
    begin
      if (i_wdata[`TC_BIT_DIR])
        dir_d = 1'b1;
      if (i_wdata[`TC_BIT_LOCK])
        lock_d = 1'b1;
    end
    // Auto-lock: armed when written one, released once buffers fill; off, lock is software's
    if (autolock_q)
    begin
      if (all_valid)
        lock_d = 1'b0;
      if (update_xfer)
        lock_d = 1'b1;
    end
    if (wr_wave && i_wdata[`TC_BIT_AUTOLOCK])
      lock_d = 1'b1;
    // Buffer valid: clears first so a write in the same cycle wins
    if (update_xfer)
      bv_d = `TC_RESET_4;
    if (wr_fclr)
      bv_d = bv_d & ~i_wdata[`TC_POS_BV +: 4];
    if (wr_fset)
      bv_d = bv_d | i_wdata[`TC_POS_BV +: 4];
    bv_d = bv_d | buf_written;
    // Hard reset returns all control to its reset state
    if (hard_reset)
    begin
      enable_d = 1'b0;
      pin_en_d = `TC_RESET_3;
      autolock_d = 1'b0;
      mode_d = `TC_RESET_3;
      level_d = `TC_RESET_3;
      split_d = 1'b0;
      lock_d = 1'b0;
      dir_d = 1'b0;
      bv_d = `TC_RESET_4;
    end
  end

  // Register file storage
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      enable_q <= 1'b0;
      pin_en_q <= `TC_RESET_3;
      autolock_q <= 1'b0;
      mode_q <= `TC_RESET_3;
      level_q <= `TC_RESET_3;
      split_q <= 1'b0;
      lock_q <= 1'b0;
      dir_q <= 1'b0;
      bv_q <= `TC_RESET_4;
    end
    else if (i_clk_en)
    begin
      enable_q <= enable_d;
      pin_en_q <= pin_en_d;
      autolock_q <= autolock_d;
      mode_q <= mode_d;
      level_q <= level_d;
      split_q <= split_d;
      lock_q <= lock_d;
      dir_q <= dir_d;
      bv_q <= bv_d;
    end
  end

  // Read mux; unmapped offsets and the command field read zero
  always_comb
  begin
    rdata_d = `TC_RESET_BYTE;
    if (i_clk_en && i_rd)
    begin
      case (i_addr)
        `TC_OFF_ENABLE: rdata_d = {7'h00, enable_q};
        `TC_OFF_WAVE: rdata_d = {1'b0, pin_en_q, autolock_q, mode_q};
        `TC_OFF_LEVEL: rdata_d = {5'h00, level_q};
        `TC_OFF_SPLIT: rdata_d = {7'h00, split_q};
        `TC_OFF_CMD_CLR, `TC_OFF_CMD_SET: rdata_d = {6'h00, lock_q, dir_q};
        `TC_OFF_BV_CLR, `TC_OFF_BV_SET: rdata_d = {4'h0, bv_q};
        default: rdata_d = `TC_RESET_BYTE;
      endcase
    end
  end

  // Event pulses toward the counter datapath
  always_comb
  begin
    xfer_d = update_xfer;
    restart_d = (cmd_code == timer_ctrl_pkg::CMD_RESTART);
    hreset_d = hard_reset;
  end

  // Per channel pin steering; normal and reserved shapes drive no pin
  for (genvar ch = 0; ch < 3; ch++)
  begin : g_chan
    always_comb
    begin
      override_d[ch] = pin_en_q[ch] && (mode_q != timer_ctrl_pkg::NORMAL_COUNT) &&
        (mode_q != `TC_MODE_RSVD_LO) && (mode_q != `TC_MODE_RSVD_HI);
      // Stopped timer shows the software level, running one the generator
      pin_d[ch] = enable_q ? i_wave_gen[ch] : level_q[ch];
      custom_lvl_d[ch] = pin_d[ch];
    end
  end

  // Output flops; pulses drop when the clock enable is low
  always_ff @(posedge i_mclk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      rdata_q <= `TC_RESET_BYTE;
      xfer_q <= 1'b0;
      restart_q <= 1'b0;
      hreset_q <= 1'b0;
      override_q <= `TC_RESET_3;
      pin_q <= `TC_RESET_3;
      custom_lvl_q <= `TC_RESET_3;
    end
    else
    begin
      rdata_q <= rdata_d;
      xfer_q <= xfer_d;
      restart_q <= restart_d;
      hreset_q <= hreset_d;
      if (i_clk_en)
      begin
        override_q <= override_d;
        pin_q <= pin_d;
        custom_lvl_q <= custom_lvl_d;
      end
    end
  end

  assign o_rdata = rdata_q;
  assign o_timer_run = enable_q;
  assign o_wave_shape_select = mode_q;
  assign o_dual_8bit_select = split_q;
  assign o_count_down = dir_q;
  assign o_transfer_lock = lock_q;
  assign o_buffer_transfer = xfer_q;
  assign o_force_restart = restart_q;
  assign o_force_hard_reset = hreset_q;
  assign o_channel_pin_override = override_q;
  assign o_channel_wave_pin = pin_q;
  assign o_custom_logic_level = custom_lvl_q;

  // Checks of the control behaviour, all on the one clock
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  a_enable_write: assert property (
    wr_en |=> (o_timer_run == $past(i_wdata[`TC_BIT_ENABLE])))
    else $error("enable bit did not follow write");

  a_pin_override: assert property (
    (i_clk_en && pin_en_q[0] && mode_q == timer_ctrl_pkg::ONE_RAMP_PWM)
      |=> o_channel_pin_override[0])
    else $error("pin override missing in pwm mode");

  a_normal_nowave: assert property (
    (i_clk_en && mode_q == timer_ctrl_pkg::NORMAL_COUNT)
      |=> (o_channel_pin_override == `TC_RESET_3))
    else $error("normal mode drove a pin");

  a_autolock_arm: assert property (
    (wr_wave && i_wdata[`TC_BIT_AUTOLOCK] && !hard_reset) |=> o_transfer_lock)
    else $error("auto-lock did not set lock");

  a_autolock_release: assert property (
    (i_clk_en && autolock_q && lock_q && all_valid && !update_xfer && !wr_wave && !wr_eset)
      |=> !o_transfer_lock)
    else $error("lock not released with valid buffers");

  a_manual_lock: assert property (
    (i_clk_en && !autolock_q && !wr_wave && !wr_eclr && !wr_eset && !hard_reset)
      |=> $stable(o_transfer_lock))
    else $error("hardware altered lock without auto-lock");

  a_lock_blocks: assert property (
    (lock_q && !force_update) |=> !o_buffer_transfer)
    else $error("locked update transferred buffers");

  a_forced_update: assert property (
    force_update |=> o_buffer_transfer)
    else $error("forced update lost");

  a_cmd_reads_zero: assert property (
    (i_clk_en && i_rd && i_addr == `TC_OFF_CMD_SET) |=> (o_rdata[`TC_POS_CMD +: 2] == 2'h0))
    else $error("command field read nonzero");

  a_hreset_enabled: assert property (
    (cmd_code == timer_ctrl_pkg::CMD_HARD_RESET && enable_q) |=> !o_force_hard_reset)
    else $error("hard reset accepted while enabled");

  a_bv_set_wins: assert property (
    (buf_written[1]) |=> bv_q[1] ##1 (bv_q[1] || $past(update_xfer) || $past(wr_fclr)
      || $past(hard_reset)))
    else $error("buffer valid lost on write");

  a_stopped_level: assert property (
    (i_clk_en && !enable_q) |=> (o_channel_wave_pin == $past(level_q)))
    else $error("stopped level not on output");

  a_run_wave: assert property (
    (i_clk_en && enable_q) |=> (o_channel_wave_pin == $past(i_wave_gen)))
    else $error("running timer did not show generator level");

  a_custom_bypass: assert property (
    (i_clk_en && !enable_q) |=> (o_custom_logic_level == $past(level_q)))
    else $error("custom logic level not bypassing pin enables");

  a_level_write: assert property (
    wr_level |=> (level_q == $past(i_wdata[`TC_POS_LEVEL +: 3])))
    else $error("level bits did not follow write");

  a_split_write: assert property (
    wr_split |=> (o_dual_8bit_select == $past(i_wdata[`TC_BIT_SPLIT])))
    else $error("split bit did not follow write");

  a_restart_pulse: assert property (
    (cmd_wr && i_wdata[`TC_POS_CMD +: 2] == timer_ctrl_pkg::CMD_RESTART) |=> o_force_restart)
    else $error("restart command lost");

  a_hreset_accept: assert property (
    (cmd_code == timer_ctrl_pkg::CMD_HARD_RESET && !enable_q)
      |=> (o_force_hard_reset && !o_transfer_lock && o_wave_shape_select == `TC_RESET_3))
    else $error("hard reset not applied while stopped");

  a_update_xfer: assert property (
    (i_clk_en && i_update_cond && !lock_q) |=> o_buffer_transfer)
    else $error("unlocked update did not transfer");

  a_bv_cleared: assert property (
    (update_xfer && !wr_fset && buf_written == `TC_RESET_4) |=> (bv_q == `TC_RESET_4))
    else $error("buffer valid not cleared by transfer");

  a_dir_set: assert property (
    (wr_eset && i_wdata[`TC_BIT_DIR] && !hard_reset) |=> o_count_down)
    else $error("set alias did not set direction");

  a_dir_clear: assert property (
    (wr_eclr && i_wdata[`TC_BIT_DIR] && !hard_reset) |=> !o_count_down)
    else $error("clear alias did not clear direction");

  a_hw_direction: assert property (
    (i_clk_en && i_hw_dir_valid && !wr_eclr && !wr_eset)
      |=> (o_count_down == $past(i_hw_dir)))
    else $error("hardware direction load lost");

  a_alias_zero: assert property (
    (wr_eset && !i_wdata[`TC_BIT_DIR] && !i_hw_dir_valid && !hard_reset)
      |=> $stable(o_count_down))
    else $error("zero alias bit changed direction");

  a_lock_rearm: assert property (
    (autolock_q && update_xfer && !hard_reset) |=> o_transfer_lock)
    else $error("auto-lock not re-armed by transfer");

endmodule // timer_waveform_control_regs
